/* File: inc/supervisor_defs.svh */
// Behaviour
// - Supply below the level picked by the tolerance select asserts both resets.
// - Resets go active within 175 us of a detected supply fail.
// - After power-up resets stay active at least 250 ms once supply is valid.
// - Resets release between 250 and 1000 ms after the supply turns valid.
// - A low level on the pushbutton input requests a reset.
// - Pushbutton is debounced; each accepted press gives a reset of at least 250 ms.
// - The 250 ms stretch starts once the pushbutton has been stably high for 10 ms.
// - Resets go active no later than 20 ms after the button is stably low.
// - Timeout select gives 150 ms grounded, 600 ms open, 1.2 s tied high.
// - Watchdog counts only while both reset outputs are inactive.
// - A strobe falling edge before expiry restarts a full timeout period.
// - Watchdog expiry drives both resets active for at least 250 ms.
// - The watchdog cannot be disabled and must always be strobed.
`ifndef SUPERVISOR_DEFS_SVH
`define SUPERVISOR_DEFS_SVH

`define CLK_PERIOD_NS 20
`define TICK_PERIOD_US 500
`define TICK_CYCLES (`TICK_PERIOD_US * 1000 / `CLK_PERIOD_NS)
`define TICKS_PER_MS 2
`define TICK_CNT_W 15
`define TIME_CNT_W 12

`define FAIL_TO_RESET_US 175
`define RESET_STRETCH_MS 250
`define RESET_STRETCH_MAX_MS 1000
`define DEBOUNCE_MS 10
`define BUTTON_TO_RESET_MS 20

`define WDOG_GND_MS 150
`define WDOG_OPEN_MS 600
`define WDOG_VCC_MS 1200

`define RESET_PHASE_RST 2'b00

`endif

/* File: inc/supervisor_pkg.sv */
`include "supervisor_defs.svh"

package supervisor_pkg;

	typedef enum logic [1:0] {
		SEL_GND = 2'b00,
		SEL_OPEN = 2'b01,
		SEL_VCC = 2'b10
	} timeoutSel_t;

	typedef enum logic [1:0] {
		PH_HOLD = 2'b00,
		PH_STRETCH = 2'b01,
		PH_RUN = 2'b10
	} phase_t;

	typedef struct packed {
		logic belowHigh;
		logic belowLow;
	} supplyLevel_t;

	typedef struct packed {
		logic pressed;
		logic [`TIME_CNT_W-1:0] cnt;
	} debounce_t;

	typedef struct packed {
		logic prevStrobe;
		logic expire;
		logic [`TIME_CNT_W-1:0] cnt;
	} wdog_t;

	typedef struct packed {
		phase_t phase;
		logic [`TIME_CNT_W-1:0] timer;
		logic [`TICK_CNT_W-1:0] divider;
		logic tick;
		logic resetOut;
		logic resetOutN;
	} supervisor_t;

	function automatic logic [`TIME_CNT_W-1:0] msToTicks(input int ms);
		msToTicks = `TIME_CNT_W'(ms * `TICKS_PER_MS);
	endfunction

endpackage

/* File: src/button_debounce.sv */
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_defs.svh"

module button_debounce
	import supervisor_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Time base
	input wire logic tick,
	// Button
	input wire logic buttonN,
	output logic pressed
);

	localparam logic [`TIME_CNT_W-1:0] DEBOUNCE_TICKS = msToTicks(`DEBOUNCE_MS);

	debounce_t s_r;
	debounce_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		// Input agrees with the accepted level: forget any partial change
		if (buttonN == !s_r.pressed) begin
			s_nxt.cnt = '0;
		end else if (tick) begin
			if (s_r.cnt == DEBOUNCE_TICKS - `TIME_CNT_W'(1)) begin
				s_nxt.pressed = !s_r.pressed;
				s_nxt.cnt = '0;
			end else begin
				s_nxt.cnt = s_r.cnt + `TIME_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pressed = s_r.pressed;

endmodule
`default_nettype wire

/* File: src/reset_supervisor_watchdog.sv */
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_defs.svh"

module reset_supervisor_watchdog
	import supervisor_pkg::*;
#(
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Supply comparator
	input wire supplyLevel_t supplyLevel,
	input wire logic supplyToleranceSelect,
	// Pushbutton
	input wire logic manualButtonN,
	// Watchdog
	input wire logic wdogStrobeN,
	input wire timeoutSel_t timeoutSelect,
	// Reset outputs
	output logic sysResetHigh,
	output logic sysResetLowN
);

	// One extra tick covers the unknown phase of the first tick
	localparam logic [`TIME_CNT_W-1:0] STRETCH_TICKS = msToTicks(`RESET_STRETCH_MS) + `TIME_CNT_W'(1);
	localparam logic [`TICK_CNT_W-1:0] TICK_LAST = `TICK_CNT_W'(TICK_CYCLES - 1);

	supervisor_t s_r;
	supervisor_t s_nxt;
	logic buttonPressed;
	logic wdExpire;
	logic supplyFail;
	logic sourceActive;

	button_debounce debounce (
		.clk(clk),
		.resetn(resetn),
		.tick(s_r.tick),
		.buttonN(manualButtonN),
		.pressed(buttonPressed)
	);

	watchdog_timer watchdog (
		.clk(clk),
		.resetn(resetn),
		.tick(s_r.tick),
		.run(s_r.phase == PH_RUN),
		.timeoutSelect(timeoutSelect),
		.wdogStrobeN(wdogStrobeN),
		.expire(wdExpire)
	);

	// Low select trips at the upper level, high select at the lower one
	assign supplyFail = supplyToleranceSelect ? supplyLevel.belowLow : supplyLevel.belowHigh;
	assign sourceActive = supplyFail || buttonPressed;

	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (s_r.divider == TICK_LAST) begin
			s_nxt.divider = '0;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.divider = s_r.divider + `TICK_CNT_W'(1);
		end

		case (s_r.phase)
			PH_HOLD: begin
				// Stretch begins once the last source has gone
				if (!sourceActive) begin
					s_nxt.phase = PH_STRETCH;
					s_nxt.timer = '0;
				end
			end
			PH_STRETCH: begin
				if (sourceActive) begin
					s_nxt.phase = PH_HOLD;
					s_nxt.timer = '0;
				end else if (s_r.tick) begin
					if (s_r.timer == STRETCH_TICKS - `TIME_CNT_W'(1)) begin
						s_nxt.phase = PH_RUN;
						s_nxt.timer = '0;
					end else begin
						s_nxt.timer = s_r.timer + `TIME_CNT_W'(1);
					end
				end
			end
			PH_RUN: begin
				if (sourceActive) begin
					s_nxt.phase = PH_HOLD;
				end else if (wdExpire) begin
					s_nxt.phase = PH_STRETCH;
					s_nxt.timer = '0;
				end
			end
			default: begin
				s_nxt.phase = PH_HOLD;
				s_nxt.timer = '0;
			end
		endcase

		s_nxt.resetOut = (s_nxt.phase != PH_RUN);
		s_nxt.resetOutN = (s_nxt.phase == PH_RUN);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_r <= '{phase: PH_HOLD, timer: '0, divider: '0, tick: 1'b0, resetOut: 1'b1, resetOutN: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sysResetHigh = s_r.resetOut;
	assign sysResetLowN = s_r.resetOutN;

endmodule
`default_nettype wire

/* File: src/watchdog_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_defs.svh"

module watchdog_timer
	import supervisor_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Control
	input wire logic tick,
	input wire logic run,
	input wire timeoutSel_t timeoutSelect,
	// Processor strobe
	input wire logic wdogStrobeN,
	// Expiry pulse
	output logic expire
);

	wdog_t s_r;
	wdog_t s_nxt;

	function automatic logic [`TIME_CNT_W-1:0] limitFor(input timeoutSel_t sel);
		case (sel)
			SEL_GND: limitFor = msToTicks(`WDOG_GND_MS);
			SEL_OPEN: limitFor = msToTicks(`WDOG_OPEN_MS);
			SEL_VCC: limitFor = msToTicks(`WDOG_VCC_MS);
			default: limitFor = msToTicks(`WDOG_OPEN_MS);
		endcase
	endfunction

	always_comb begin
		logic [`TIME_CNT_W-1:0] limit;
		limit = limitFor(timeoutSelect);
		s_nxt = s_r;
		s_nxt.prevStrobe = wdogStrobeN;
		s_nxt.expire = 1'b0;
		// No enable term: runs whenever reset is released
		if (!run) begin
			s_nxt.cnt = '0;
		end else if (s_r.prevStrobe && !wdogStrobeN) begin
			s_nxt.cnt = '0;
		end else if (tick) begin
			if (s_r.cnt >= limit - `TIME_CNT_W'(1)) begin
				s_nxt.expire = 1'b1;
				s_nxt.cnt = '0;
			end else begin
				s_nxt.cnt = s_r.cnt + `TIME_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_r <= '{prevStrobe: 1'b1, expire: 1'b0, cnt: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign expire = s_r.expire;

endmodule
`default_nettype wire

/* File: verification/strobe_proc.sv */
`timescale 1ns/1ps
`default_nettype none
module strobe_proc (
	// Clock
	input wire logic clk,
	// Strobing on or off
	input wire logic kickOn,
	// Strobe
	output logic wdogStrobeN
);
	int cnt = 0;
	initial wdogStrobeN = 1'b1;
	// Two-cycle low every 50 ms, inside the shortest timeout
	always @(posedge clk) begin
		cnt <= (cnt == 999) ? 0 : cnt + 1;
		wdogStrobeN <= !(kickOn && cnt < 2);
	end
endmodule
`default_nettype wire

/* File: verification/sup_props.sv */
`timescale 1ns/1ps
`default_nettype none
module sup_props
	import supervisor_pkg::*;
#(parameter int TICK_CYCLES = 10) (
	// Watched ports
	input wire logic clk,
	input wire logic resetn,
	input wire supplyLevel_t supplyLevel,
	input wire logic supplyToleranceSelect,
	input wire logic manualButtonN,
	input wire logic wdogStrobeN,
	input wire timeoutSel_t timeoutSelect,
	input wire logic sysResetHigh,
	input wire logic sysResetLowN
);
	localparam int T = TICK_CYCLES;
	int lowCnt, hiCnt, quiet, hiQuiet, wdCnt, lim;
	logic fail, src, prevSt;
	assign fail = supplyToleranceSelect ? supplyLevel.belowLow : supplyLevel.belowHigh;
	assign src = fail | !manualButtonN;
	assign lim = T * (timeoutSelect == SEL_GND ? 300 : timeoutSelect == SEL_VCC ? 2400 : 1200);
	// Cycle counters for the long intervals
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lowCnt <= 0;
			hiCnt <= 0;
			quiet <= 0;
			hiQuiet <= 0;
			wdCnt <= 0;
			prevSt <= 1'b1;
		end else begin
			lowCnt <= manualButtonN ? 0 : lowCnt + 1;
			hiCnt <= sysResetHigh ? hiCnt + 1 : 0;
			quiet <= src ? 0 : quiet + 1;
			hiQuiet <= (sysResetHigh && !src) ? hiQuiet + 1 : 0;
			wdCnt <= (sysResetHigh || (prevSt && !wdogStrobeN)) ? 0 : wdCnt + 1;
			prevSt <= wdogStrobeN;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	a_out_compl: assert property (sysResetHigh != sysResetLowN) else $error("outputs not complementary");
	a_fail_fast: assert property (fail |-> ##[1:2] sysResetHigh) else $error("fail late");
	a_fail_hold: assert property (fail [*3] |-> sysResetHigh) else $error("fail dropped");
	a_button_delay: assert property (lowCnt >= 40 * T |-> sysResetHigh) else $error("button late");
	a_stretch_min: assert property ($fell(sysResetHigh) |-> hiCnt >= 500 * T && quiet >= 500 * T)
		else $error("stretch short");
	a_release_max: assert property (hiQuiet < 2000 * T) else $error("release late");
	a_wdog_early: assert property ($rose(sysResetHigh) && !src |-> wdCnt >= lim - T) else $error("wdog early");
	a_wdog_late: assert property (wdCnt <= lim + 2 * T) else $error("wdog late");
	c_fail: cover property (fail ##1 sysResetHigh);
	c_button: cover property (lowCnt == 40 * T);
	c_wdog: cover property ($rose(sysResetHigh) && !src);
endmodule
bind reset_supervisor_watchdog sup_props #(.TICK_CYCLES(TICK_CYCLES)) props (.clk, .resetn, .supplyLevel,
	.supplyToleranceSelect, .manualButtonN, .wdogStrobeN, .timeoutSelect, .sysResetHigh, .sysResetLowN);
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin totalChecks++; if ((got) !== (ex)) begin numErrors++; \
	$display("MISMATCH %s exp %0d got %0d", nm, ex, got); end end
module tb
	import supervisor_pkg::*;
;
	localparam int TC = 10;
	logic clk = 1'b0, resetn = 1'b0, tolSel = 1'b0, buttonN = 1'b1, kickOn = 1'b1;
	supplyLevel_t level = '0;
	timeoutSel_t sel = SEL_GND;
	logic strobeN, rstHigh, rstLowN;
	int numErrors = 0, totalChecks = 0, cycles = 0, n;
	always #10 clk = ~clk;
	strobe_proc proc (.clk(clk), .kickOn(kickOn), .wdogStrobeN(strobeN));
	reset_supervisor_watchdog #(.TICK_CYCLES(TC)) dut (.clk(clk), .resetn(resetn), .supplyLevel(level),
		.supplyToleranceSelect(tolSel), .manualButtonN(buttonN), .wdogStrobeN(strobeN),
		.timeoutSelect(sel), .sysResetHigh(rstHigh), .sysResetLowN(rstLowN));
	task automatic complete_run();
		$display("checks %0d mismatches %0d", totalChecks, numErrors);
		if (numErrors == 0 && totalChecks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 100000) begin
			numErrors++;
			complete_run();
		end
	end
	task automatic waitRel(input string nm);
		n = 0;
		while (rstLowN !== 1'b1 && n < 2100 * TC) begin
			@(negedge clk);
			n++;
		end
		`CHK(nm, 1'b1, (n >= 500 * TC && n <= 2000 * TC))
		$display("test %s done", nm);
	endtask
	task automatic supplyTest(input logic supply_tolerance_select);
		@(posedge clk);
		tolSel <= supply_tolerance_select;
		level <= 2'b10;
		repeat (20) @(negedge clk);
		`CHK("tolerance", supply_tolerance_select, rstLowN)
		@(posedge clk);
		level <= 2'b11;
		repeat (2) @(posedge clk);
		@(negedge clk);
		`CHK("trip", 1'b1, rstHigh)
		repeat (20) @(posedge clk);
		level <= 2'b00;
		waitRel("supply");
	endtask
	task automatic buttonTest();
		@(posedge clk);
		buttonN <= 1'b0;
		repeat (100) @(posedge clk);
		buttonN <= 1'b1;
		repeat (400) @(negedge clk);
		`CHK("short press", 1'b1, rstLowN)
		@(posedge clk);
		buttonN <= 1'b0;
		repeat (400) @(negedge clk);
		`CHK("press", 1'b0, rstLowN)
		repeat (3000) @(posedge clk);
		buttonN <= 1'b1;
		waitRel("button");
	endtask
	task automatic wdTest(input timeoutSel_t s, input int lim, input logic kick);
		@(posedge clk);
		sel <= s;
		kickOn <= kick;
		level <= 2'b11;
		repeat (10) @(posedge clk);
		level <= 2'b00;
		waitRel("wdog rearm");
		n = 0;
		while (rstHigh !== 1'b1 && n < 2 * lim * TC) begin
			@(negedge clk);
			n++;
		end
		`CHK("expiry", !kick, (n >= (lim - 1) * TC && n <= (lim + 2) * TC))
		$display("test expiry %0d done", lim);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		waitRel("powerup");
		supplyTest(1'b1);
		supplyTest(1'b0);
		buttonTest();
		wdTest(SEL_GND, 300, 1'b1);
		wdTest(SEL_OPEN, 1200, 1'b0);
		wdTest(SEL_VCC, 2400, 1'b0);
		complete_run();
	end
endmodule
`default_nettype wire
